// ---- hdl/counter_wd_pkg.sv ----
// Shared constants and types for the counter-array channel two watchdog.
package counter_wd_pkg;

  // Register addresses on the special function register port.
  localparam logic [7:0] CTRL_REG_ADDR   = 8'hD8;
  localparam logic [7:0] MODE_REG_ADDR   = 8'hD9;
  localparam logic [7:0] CH_MODE_ADDR    = 8'hDC;
  localparam logic [7:0] WD_OFFSET_ADDR  = 8'hEB;
  localparam logic [7:0] WD_UPDATE_ADDR  = 8'hEC;
  localparam logic [7:0] CNT_LO_ADDR     = 8'hF9;
  localparam logic [7:0] CNT_HI_ADDR     = 8'hFA;

  // Counter mode register fields.
  localparam int unsigned MD_IDLE_BIT    = 7;
  localparam int unsigned MD_WDEN_BIT    = 6;
  localparam int unsigned MD_CPS_LSB     = 1;
  localparam int unsigned CPS_W          = 3;

  // Counter control register fields.
  localparam int unsigned CT_RUN_BIT     = 6;
  localparam int unsigned CT_FLAG_BIT    = 2;

  // Channel mode register fields.
  localparam int unsigned MB_WIDE        = 7;
  localparam int unsigned MB_CMP         = 6;
  localparam int unsigned MB_RISE        = 5;
  localparam int unsigned MB_FALL        = 4;
  localparam int unsigned MB_MAT         = 3;
  localparam int unsigned MB_TOG         = 2;
  localparam int unsigned MB_PWM         = 1;
  localparam int unsigned MB_IRQ         = 0;

  // Reset values; the watchdog enable bit is set by every reset.
  localparam logic [7:0]  MODE_RST       = 8'h40;
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  localparam logic [7:0]  CH_MODE_RST    = 8'h00;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [15:0] WORD_ZERO      = 16'h0000;
  localparam logic [15:0] WORD_ONE       = 16'h0001;

  // Mode forced onto the channel while the watchdog runs: compare plus match.
  localparam logic [7:0]  CH_MODE_SWTIMER = 8'h48;

  // Channel behaviours decoded from the mode bits.
  typedef enum logic [2:0] {
    FN_OFF, FN_CAPTURE, FN_TIMER, FN_TOGGLE, FN_FREQ, FN_PWM8, FN_WIDE_MODULATION_SELECT
  } ch_func_t;

endpackage

// ---- hdl/pin_sync3.sv ----
// Three-stage pin synchroniser with edge pulses for the capture input.
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic clk_en,
  // Pin side.
  input  wire logic pin_async,
  // Synchronised side.
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic       level_q;
  logic       level_d;

  // Only stages one and two feed the agreement check, so stage zero meets
  // nothing but the next flip-flop.
  always_comb begin
    stage_d = {stage_q[1:0], pin_async};
    level_d = level_q;
    if (stage_q[1] == stage_q[2]) begin
      level_d = stage_q[2];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_q <= 3'h0;
      level_q <= 1'b0;
    end else if (clk_en) begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  // Edges are one-cycle pulses of the accepted level.
  assign level = level_q;
  assign rise  = clk_en & level_d & ~level_q;
  assign fall  = clk_en & ~level_d & level_q;

endmodule
`default_nettype wire

// ---- hdl/counter_channel_two_watchdog.sv ----
// Channel two of the counter array with its watchdog mode and register locks.
//
// Contract
// - Watchdog enable bit set makes channel two act as the watchdog.
// - Watchdog compares channel high byte to counter high; low byte holds offset.
// - Every reset turns the watchdog on.
// - Watchdog on keeps the counter running whatever the run bit says.
// - Watchdog on ignores writes to counter low and high bytes.
// - Watchdog on freezes the counter clock source select field.
// - Watchdog on freezes the idle-stop control bit.
// - Watchdog on forces channel two into software timer behaviour.
// - Watchdog on discards writes to the channel mode register.
// - Run bit writes do not change counter state while watchdog is on.
// - Run bit reads zero unless software itself set it.
// - Watchdog on, update high byte equal to counter high byte raises system reset.
// - Watchdog on makes an update write load counter high byte plus offset.
// - Offset counts low-byte overflows; first may take up to 256 clocks.
// - Mode bit 7 picks 8-bit or 16-bit modulation.
// - Mode bit 6 enables the comparator.
// - Mode bit 5 captures rising edges, bit 4 falling edges.
// - Mode bit 3 makes a compare match set the channel flag.
// - Mode bit 2 toggles the pin on match; with bit 1, frequency output.
// - Mode bit 1 drives modulated output sized by the width bit.
// - Mode bit 0 lets the channel flag raise an interrupt request.
`timescale 1ns/10ps
`default_nettype none
module counter_channel_two_watchdog
  import counter_wd_pkg::*;
#(
  parameter int unsigned TICK_SRCS = 8
) (
  // Clock, reset and clock enable.
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  input  wire logic                 clk_en,
  // Special function register port.
  input  wire logic [7:0]           sfr_addr,
  input  wire logic                 sfr_wr,
  input  wire logic                 sfr_rd,
  input  wire logic [7:0]           sfr_wdata,
  output logic      [7:0]           sfr_rdata,
  // Counter clock sources and idle indication, same clock domain.
  input  wire logic [TICK_SRCS-1:0] count_tick,
  input  wire logic                 cpu_idle,
  // Channel pins and requests.
  input  wire logic                 capture_pin,
  output logic                      channel_output_pin,
  output logic                      channel_irq,
  output logic                      wd_reset_req
);

  // Sorts the mode bits into one channel behaviour.
  function automatic ch_func_t decode_mode(input logic [7:0] m);
    ch_func_t f;
    f = FN_OFF;
    if (m[MB_RISE] || m[MB_FALL]) begin
      f = FN_CAPTURE;
    end else if (m[MB_CMP] && m[MB_TOG] && m[MB_PWM]) begin
      f = FN_FREQ;
    end else if (m[MB_CMP] && m[MB_PWM]) begin
      f = m[MB_WIDE] ? FN_WIDE_MODULATION_SELECT : FN_PWM8;
    end else if (m[MB_CMP] && m[MB_TOG]) begin
      f = FN_TOGGLE;
    end else if (m[MB_CMP]) begin
      f = FN_TIMER;
    end
    return f;
  endfunction

  logic [7:0]  mode_q, mode_d;
  logic        run_q, run_d;
  logic        flag_q, flag_d;
  logic [7:0]  ch_mode_q, ch_mode_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] cmp_q, cmp_d;
  logic        pin_q, pin_d;
  logic        irq_q, irq_d;
  logic        wdrst_q, wdrst_d;
  logic [7:0]  rdata_q, rdata_d;

  logic        cap_level;
  logic        cap_rise;
  logic        cap_fall;
  logic        wd_en;
  logic        tick;
  logic [7:0]  eff_mode;
  ch_func_t    func;
  logic        match;
  logic        lo_match;

  pin_sync3 u_cap_sync (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .pin_async (capture_pin),
    .level     (cap_level),
    .rise      (cap_rise),
    .fall      (cap_fall)
  );

  // Watchdog mode and the channel behaviour it forces.
  assign wd_en    = mode_q[MD_WDEN_BIT];
  assign eff_mode = wd_en ? (CH_MODE_SWTIMER | (ch_mode_q & 8'h01))
                          : ch_mode_q;
  assign func     = decode_mode(eff_mode);

  // Counter advances on the selected source; the watchdog overrides the run bit.
  assign tick = count_tick[mode_q[MD_CPS_LSB +: CPS_W]]
              & (run_q | wd_en)
              & ~(mode_q[MD_IDLE_BIT] & cpu_idle);

  // Compare events are taken on the count just reached.
  assign match    = tick & eff_mode[MB_CMP] & ((cnt_q + WORD_ONE) == cmp_q);
  assign lo_match = tick & eff_mode[MB_CMP] & ((cnt_q[7:0] + 8'h01) == cmp_q[7:0]);

  // Next state of counter, channel and control registers.
  always_comb begin
    mode_d    = mode_q;
    run_d     = run_q;
    flag_d    = flag_q;
    ch_mode_d = ch_mode_q;
    cnt_d     = cnt_q;
    cmp_d     = cmp_q;
    pin_d     = pin_q;
    if (tick) begin
      cnt_d = cnt_q + WORD_ONE;
    end

    // Register writes, with the watchdog locks applied.
    if (sfr_wr) begin
      unique case (sfr_addr)
        MODE_REG_ADDR: begin
          mode_d[MD_WDEN_BIT] = sfr_wdata[MD_WDEN_BIT];
          if (!wd_en) begin
            mode_d[MD_IDLE_BIT] = sfr_wdata[MD_IDLE_BIT];
            mode_d[MD_CPS_LSB +: CPS_W] = sfr_wdata[MD_CPS_LSB +: CPS_W];
          end
        end
        CTRL_REG_ADDR: begin
          // The stored bit changes; under the watchdog the counter stays forced on.
          run_d = sfr_wdata[CT_RUN_BIT];
          if (!sfr_wdata[CT_FLAG_BIT]) begin
            flag_d = 1'b0;
          end
        end
        CH_MODE_ADDR: begin
          if (!wd_en) begin
            ch_mode_d = sfr_wdata;
          end
        end
        CNT_LO_ADDR: begin
          if (!wd_en) begin
            cnt_d[7:0] = sfr_wdata;
          end
        end
        CNT_HI_ADDR: begin
          if (!wd_en) begin
            cnt_d[15:8] = sfr_wdata;
          end
        end
        WD_OFFSET_ADDR: begin
          cmp_d[7:0] = sfr_wdata;
        end
        WD_UPDATE_ADDR: begin
          // The offset is in high-byte steps, so the first overflow may come
          // up to a full low-byte period after the write.
          if (wd_en) begin
            cmp_d[15:8] = cnt_q[15:8] + cmp_q[7:0];
          end else begin
            cmp_d[15:8] = sfr_wdata;
          end
        end
        default: begin
        end
      endcase
    end

    // Channel behaviour; the watchdog forces the timer branch, whose match then sets no flag and moves no pin.
    unique case (func)
      FN_CAPTURE: begin
        if ((cap_rise && eff_mode[MB_RISE]) || (cap_fall && eff_mode[MB_FALL])) begin
          cmp_d  = cnt_q;
          flag_d = 1'b1;
        end
      end
      FN_TIMER, FN_TOGGLE: begin
        if (match && !wd_en) begin
          if (eff_mode[MB_MAT]) begin
            flag_d = 1'b1;
          end
          if (eff_mode[MB_TOG]) begin
            pin_d = ~pin_q;
          end
        end
      end
      FN_FREQ: begin
        // Each low-byte match toggles and advances the next edge by the step.
        if (lo_match) begin
          pin_d      = ~pin_q;
          cmp_d[7:0] = cmp_q[7:0] + cmp_q[15:8];
        end
      end
      FN_PWM8: begin
        if (tick) begin
          pin_d = (cnt_d[7:0] >= cmp_q[7:0]);
        end
      end
      FN_WIDE_MODULATION_SELECT: begin
        if (tick) begin
          pin_d = (cnt_d >= cmp_q);
        end
      end
      FN_OFF: begin
      end
    endcase
  end

  // Watchdog fires whenever the update byte meets the counter high byte.
  always_comb begin
    wdrst_d = wd_en & (cmp_q[15:8] == cnt_q[15:8]);
    irq_d   = flag_d & eff_mode[MB_IRQ];
  end

  // Read data; the run bit shows only what software wrote.
  always_comb begin
    rdata_d = rdata_q;
    if (sfr_rd) begin
      unique case (sfr_addr)
        MODE_REG_ADDR:  rdata_d = mode_q;
        CTRL_REG_ADDR:  rdata_d = ({7'h00, run_q} << CT_RUN_BIT)
                                | ({7'h00, flag_q} << CT_FLAG_BIT);
        CH_MODE_ADDR:   rdata_d = ch_mode_q;
        CNT_LO_ADDR:    rdata_d = cnt_q[7:0];
        CNT_HI_ADDR:    rdata_d = cnt_q[15:8];
        WD_OFFSET_ADDR: rdata_d = cmp_q[7:0];
        WD_UPDATE_ADDR: rdata_d = cmp_q[15:8];
        default:        rdata_d = BYTE_ZERO;
      endcase
    end
  end

  // State registers; the mode reset value turns the watchdog on.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q    <= MODE_RST;
      run_q     <= CTRL_RST[CT_RUN_BIT];
      flag_q    <= CTRL_RST[CT_FLAG_BIT];
      ch_mode_q <= CH_MODE_RST;
      cnt_q     <= WORD_ZERO;
      cmp_q     <= WORD_ZERO;
      pin_q     <= 1'b0;
      irq_q     <= 1'b0;
      wdrst_q   <= 1'b0;
      rdata_q   <= BYTE_ZERO;
    end else if (clk_en) begin
      mode_q    <= mode_d;
      run_q     <= run_d;
      flag_q    <= flag_d;
      ch_mode_q <= ch_mode_d;
      cnt_q     <= cnt_d;
      cmp_q     <= cmp_d;
      pin_q     <= pin_d;
      irq_q     <= irq_d;
      wdrst_q   <= wdrst_d;
      rdata_q   <= rdata_d;
    end
  end

  assign sfr_rdata          = rdata_q;
  assign channel_output_pin = pin_q;
  assign channel_irq        = irq_q;
  assign wd_reset_req       = wdrst_q;

  // Checks against the watchdog locks and channel behaviour.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_wd_reset_match: assert property (arst_n && clk_en && wd_en
    && cmp_q[15:8] == cnt_q[15:8] |=> wd_reset_req) else $error("watchdog match gave no reset");
  a_no_reset_off: assert property (clk_en && !wd_en |=> !wd_reset_req)
    else $error("reset raised with watchdog off");
  a_cnt_forced_on: assert property (clk_en && wd_en && tick |=> cnt_q == $past(cnt_q) + WORD_ONE)
    else $error("counter did not advance under watchdog");
  a_cnt_wr_lock: assert property (clk_en && wd_en && !tick && sfr_wr
    && (sfr_addr == CNT_LO_ADDR || sfr_addr == CNT_HI_ADDR) |=> $stable(cnt_q))
    else $error("counter written while locked");
  a_cps_frozen: assert property (clk_en && wd_en && sfr_wr && sfr_addr == MODE_REG_ADDR
    |=> mode_q[MD_CPS_LSB +: CPS_W] == $past(mode_q[MD_CPS_LSB +: CPS_W]))
    else $error("clock select changed while locked");
  a_idle_frozen: assert property (clk_en && wd_en && sfr_wr && sfr_addr == MODE_REG_ADDR
    |=> mode_q[MD_IDLE_BIT] == $past(mode_q[MD_IDLE_BIT]))
    else $error("idle control changed while locked");
  a_chmode_lock: assert property (clk_en && wd_en |=> $stable(ch_mode_q))
    else $error("channel mode changed while locked");
  a_update_load: assert property (clk_en && wd_en && sfr_wr && sfr_addr == WD_UPDATE_ADDR
    |=> cmp_q[15:8] == 8'($past(cnt_q[15:8]) + $past(cmp_q[7:0])))
    else $error("update did not load high plus offset");
  a_run_read: assert property (clk_en && sfr_rd && sfr_addr == CTRL_REG_ADDR && !run_q
    |=> !sfr_rdata[CT_RUN_BIT])
    else $error("run bit read high without software enable");
  a_forced_timer: assert property (wd_en |-> func == FN_TIMER)
    else $error("channel not in timer behaviour under watchdog");
  a_irq_gate: assert property (clk_en && !eff_mode[MB_IRQ] |=> !channel_irq)
    else $error("interrupt raised while masked");

  c_wd_fires: cover property (wd_en && wd_reset_req);
  c_wd_update: cover property (wd_en && sfr_wr && sfr_addr == WD_UPDATE_ADDR);
  c_wd_off: cover property (wd_en ##1 !wd_en);
  c_capture: cover property (func == FN_CAPTURE && flag_q);

endmodule
`default_nettype wire

// ---- tb/test_counter_channel_two_watchdog.sv ----
// Self-checking bench for the counter-array channel two watchdog.
`timescale 1ns/10ps
`default_nettype none
module test_counter_channel_two_watchdog
  import counter_wd_pkg::*;
;
  // Stimulus and observed outputs.
  logic       sys_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [7:0] count_tick = 8'h00;
  logic       cpu_idle = 1'b0;
  logic       capture_pin = 1'b0;
  logic       channel_output_pin;
  logic       channel_irq;
  logic       wd_reset_req;
  logic [7:0] rv;
  logic       pin0;
  int         errors = 0;
  int         tests_run = 0;

  counter_channel_two_watchdog #(.TICK_SRCS(8)) DUT (
    .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(1'b1),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .count_tick(count_tick), .cpu_idle(cpu_idle), .capture_pin(capture_pin),
    .channel_output_pin(channel_output_pin), .channel_irq(channel_irq),
    .wd_reset_req(wd_reset_req)
  );

  // A 5 ns period gives the 200 MHz system clock.
  always #2.5 sys_clk = ~sys_clk;

  // Prints the counts and the verdict, then stops the run.
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Case equality keeps an unknown value from passing as a match.
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One register write; the strobe drops after the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge sys_clk);
    sfr_wr    <= 1'b0;
  endtask

  // One register read; the registered data is settled after the taking edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge sys_clk);
    sfr_rd   <= 1'b0;
    #1;
    d = sfr_rdata;
  endtask

  // Exactly n ticks on clock source zero, one per cycle.
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      count_tick <= 8'h01;
    end
    @(posedge sys_clk);
    count_tick <= 8'h00;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Bounded wait on the reset request; running out ends the run.
  task automatic wait_req(input logic exp, input int bound);
    int n;
    n = 0;
    while (wd_reset_req !== exp && n < bound) begin
      settle(1);
      n++;
    end
    chk("wd_reset_req", {7'h00, wd_reset_req}, {7'h00, exp});
    if (wd_reset_req !== exp) results();
  endtask

  // Reset leaves the watchdog on and the run bit clear.
  task automatic t_reset_state();
    rd(MODE_REG_ADDR, rv);
    chk("mode after reset", rv, MODE_RST);
    rd(CTRL_REG_ADDR, rv);
    chk("control after reset", rv, CTRL_RST);
    rd(CH_MODE_ADDR, rv);
    chk("channel mode after reset", rv, CH_MODE_RST);
    wait_req(1'b1, 4);
  endtask

  // Locked fields must ignore writes while the watchdog runs.
  task automatic t_locks();
    wr(CNT_LO_ADDR, 8'h5A);
    wr(CNT_HI_ADDR, 8'hA5);
    wr(MODE_REG_ADDR, 8'hCE);
    wr(CH_MODE_ADDR, 8'h42);
    rd(CNT_LO_ADDR, rv);
    chk("counter low locked", rv, 8'h00);
    rd(CNT_HI_ADDR, rv);
    chk("counter high locked", rv, 8'h00);
    rd(MODE_REG_ADDR, rv);
    chk("select and idle frozen", rv, MODE_RST);
  endtask

  // The counter runs with the run bit clear, both before software sets it and after software clears it.
  task automatic t_forced_run();
    ticks(16);
    rd(CNT_LO_ADDR, rv);
    chk("forced counting", rv, 8'h10);
    wr(CTRL_REG_ADDR, 8'h40);
    rd(CTRL_REG_ADDR, rv);
    chk("run bit set by software", rv, 8'h40);
    wr(CTRL_REG_ADDR, 8'h00);
    ticks(16);
    rd(CNT_LO_ADDR, rv);
    chk("counting after run cleared", rv, 8'h20);
    rd(CTRL_REG_ADDR, rv);
    chk("run bit reads zero", rv, 8'h00);
  endtask

  // Update loads high byte plus offset; reset fires on the exact overflow.
  task automatic t_update();
    wr(WD_OFFSET_ADDR, 8'h01);
    wr(WD_UPDATE_ADDR, 8'h77);
    rd(WD_UPDATE_ADDR, rv);
    chk("update value", rv, 8'h01);
    wait_req(1'b0, 4);
    ticks(8'hDF);
    settle(3);
    chk("no reset before overflow", {7'h00, wd_reset_req}, 8'h00);
    ticks(1);
    settle(3);
    chk("reset on high byte match", {7'h00, wd_reset_req}, 8'h01);
  endtask

  // Disabling releases the locks and stops the forced counting.
  task automatic t_disable();
    logic [7:0] m;
    wr(MODE_REG_ADDR, 8'h00);
    wait_req(1'b0, 4);
    rd(CH_MODE_ADDR, rv);
    chk("locked mode write discarded", rv, 8'h00);
    ticks(4);
    rd(CNT_LO_ADDR, rv);
    chk("counter stopped", rv, 8'h00);
    wr(MODE_REG_ADDR, 8'h8E);
    rd(MODE_REG_ADDR, rv);
    chk("select and idle writable", rv, 8'h8E);
    wr(MODE_REG_ADDR, 8'h00);
    // Every mode bit alone must store and read back.
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      wr(CH_MODE_ADDR, m);
      rd(CH_MODE_ADDR, rv);
      chk("channel mode bit", rv, m);
    end
  endtask

  // Match sets the flag, the enabled irq follows it, toggle inverts the pin.
  task automatic t_match();
    wr(CNT_LO_ADDR, 8'h10);
    wr(CNT_HI_ADDR, 8'h00);
    wr(WD_OFFSET_ADDR, 8'h12);
    wr(WD_UPDATE_ADDR, 8'h00);
    wr(CH_MODE_ADDR, 8'h49);
    wr(CTRL_REG_ADDR, 8'h40);
    ticks(2);
    settle(2);
    chk("irq on match", {7'h00, channel_irq}, 8'h01);
    rd(CTRL_REG_ADDR, rv);
    chk("flag on match", rv, 8'h44);
    wr(CTRL_REG_ADDR, 8'h00);
    settle(2);
    chk("irq after clear", {7'h00, channel_irq}, 8'h00);
    wr(CNT_LO_ADDR, 8'h10);
    wr(CH_MODE_ADDR, 8'h44);
    settle(2);
    pin0 = channel_output_pin;
    wr(CTRL_REG_ADDR, 8'h40);
    ticks(2);
    settle(2);
    chk("toggle on match", {7'h00, channel_output_pin}, {7'h00, ~pin0});
    wr(CTRL_REG_ADDR, 8'h00);
  endtask

  // Compare 0x0112 against counter 0x0012 tells 8-bit from 16-bit width.
  // The pin only moves on a tick, so each width gets one tick onto 0x0012.
  task automatic t_pwm();
    wr(WD_UPDATE_ADDR, 8'h01);
    wr(CH_MODE_ADDR, 8'hC2);
    wr(CNT_LO_ADDR, 8'h11);
    wr(CTRL_REG_ADDR, 8'h40);
    ticks(1);
    settle(2);
    chk("wide modulation", {7'h00, channel_output_pin}, 8'h00);
    wr(CH_MODE_ADDR, 8'h42);
    wr(CNT_LO_ADDR, 8'h11);
    ticks(1);
    settle(2);
    chk("narrow modulation", {7'h00, channel_output_pin}, 8'h01);
    wr(CTRL_REG_ADDR, 8'h00);
  endtask

  // Frequency output: each low-byte match toggles and steps the compare by four.
  task automatic t_freq();
    wr(CH_MODE_ADDR, 8'h46);
    wr(CNT_LO_ADDR, 8'h00);
    wr(WD_OFFSET_ADDR, 8'h02);
    wr(WD_UPDATE_ADDR, 8'h04);
    wr(CTRL_REG_ADDR, 8'h40);
    settle(1);
    pin0 = channel_output_pin;
    ticks(2);
    settle(2);
    chk("frequency first edge", {7'h00, channel_output_pin}, {7'h00, ~pin0});
    ticks(4);
    settle(2);
    chk("frequency second edge", {7'h00, channel_output_pin}, {7'h00, pin0});
    wr(CTRL_REG_ADDR, 8'h00);
    rd(WD_OFFSET_ADDR, rv);
    chk("frequency next compare", rv, 8'h0A);
  endtask

  // Sets mode and counter, moves the pin, then reads the compare low byte.
  task automatic cap(input logic [7:0] md, input logic [7:0] c, input logic p,
                     input logic [7:0] exp);
    wr(CH_MODE_ADDR, md);
    wr(CNT_LO_ADDR, c);
    @(posedge sys_clk);
    capture_pin <= p;
    settle(8);
    rd(WD_OFFSET_ADDR, rv);
    chk("capture", rv, exp);
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset_state();
    t_locks();
    t_forced_run();
    t_update();
    t_disable();
    t_match();
    t_pwm();
    cap(8'h10, 8'h34, 1'b1, 8'h12);
    cap(8'h10, 8'h56, 1'b0, 8'h56);
    cap(8'h20, 8'h78, 1'b1, 8'h78);
    t_freq();
    results();
  end

  // Cuts a hang short well inside the cycle budget.
  initial begin
    #200000;
    errors++;
    results();
  end
endmodule
`default_nettype wire
